/* rtl/overlay_window_config_regs.sv */
// Added by the designer: the Wishbone slave port.
`timescale 1ns/1ns
// Summary of operation
// - Window 1 control resets to all zero: swaps off, burst 16, per-plane, disabled.
// - Clearing bit 0 stops window video and control at once; setting enables them.
// - Bit 18 set reverses bit order of fetched window data.
// - Bit 17 set swaps bytes within fetched window data words.
// - Bit 16 set swaps the two half-words of fetched data words.
// - Burst field 00 selects 16 words, 01 eight words, 10 four words.
// - Bit 6 selects per-plane blending when zero, per-pixel when one.
// - Format codes 0 to 3 mean 1, 2, 4, 8 bpp; 8 bpp palette-indexed.
// - Codes 4 to 7 are A1R2G3B2, R5G6B5, A1R5G5B5, I1R5G5B5.
// - Codes 8 to 10 are unpacked R6G6B6, A1R6G6B5, A1R6G6B6.
// - Codes 11 to 13 are unpacked R8G8B8, A1R8G8B7, A1R8G8B8; 111x reserved.
// - Code 1101 under per-plane blending carries 28 bpp with 4-bit alpha.
// - Per-plane blending: alpha select picks first or second plane alpha set.
// - Per-pixel: select 0 uses alpha flag/chroma key, 1 uses bits 27:24 (24 bpp).
// - Window 0 top-left corner: X in bits 21:11, Y in 10:0, reset zero.
// - Window 0 bottom-right corner: X in bits 21:11, Y in 10:0, reset zero.
module overlay_window_config_regs
   import overlay_window_pkg::*;
#(
   parameter int DATA_W = 32,
   parameter int PIXEL_W = 32,
   parameter int VCTL_W = 4
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [31:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [DATA_W-1:0] wb_dat_i,
   output logic [DATA_W-1:0] wb_dat_o,
   output logic wb_ack_o,
   // Fetched window data path
   input wire logic [31:0] fetch_data_i,
   output logic [31:0] fetch_data_o,
   // Window video path
   input wire logic [PIXEL_W-1:0] video_data_i,
   input wire logic [VCTL_W-1:0] video_ctl_i,
   output logic [PIXEL_W-1:0] video_data_o,
   output logic [VCTL_W-1:0] video_ctl_o,
   // Decoded configuration
   output logic window_output_enable_o,
   output logic [4:0] dma_burst_words_o,
   output logic blend_category_select_o,
   output logic [5:0] bits_per_pixel_o,
   output logic palette_indexed_o,
   output logic pixel_has_alpha_o,
   output logic format_reserved_o,
   output alpha_source_t alpha_source_o,
   output logic [3:0] pixel_alpha_o,
   output logic alpha_select_illegal_o,
   // Window 0 corners
   output logic [10:0] top_left_x_o,
   output logic [10:0] top_left_y_o,
   output logic [10:0] bottom_right_x_o,
   output logic [10:0] bottom_right_y_o
);

   function automatic logic [31:0] merge_bytes(input logic [31:0] old_value, input logic [31:0] new_value,
                                               input logic [3:0] sel, input logic [31:0] mask);
      logic [31:0] merged;
      merged = old_value;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            merged[i*8 +: 8] = new_value[i*8 +: 8];
         end
      end
      return merged & mask;
   endfunction

   logic [31:0] window1_control;
   logic [31:0] window0_top_left_position;
   logic [31:0] window0_bottom_right_position;
   logic ack;
   logic [31:0] read_data;
   logic [31:0] swapped_data;
   logic [PIXEL_W-1:0] video_data;
   logic [VCTL_W-1:0] video_ctl;

   // Bus decode
   wire request = wb_cyc_i & wb_stb_i & ~ack;
   wire write_strobe = request & wb_we_i;
   wire hit_control = (wb_adr_i == ADDR_WINDOW1_CONTROL);
   wire hit_top_left = (wb_adr_i == ADDR_WINDOW0_TOP_LEFT);
   wire hit_bottom_right = (wb_adr_i == ADDR_WINDOW0_BOTTOM_RIGHT);
   wire hit_status = (wb_adr_i == ADDR_WINDOW1_STATUS);
   wire [31:0] bus_wdata = 32'(wb_dat_i);

   // Control fields
   wire window_output_enable = window1_control[POS_ENABLE];
   wire alpha_sel = window1_control[POS_ALPHA_SEL];
   wire blend_category_select = window1_control[POS_BLEND];
   wire [1:0] dma_burst_size_select = window1_control[POS_BURST_HI:POS_BURST_LO];
   wire bit_reverse_enable = window1_control[POS_BIT_REVERSE];
   wire byte_swap_enable = window1_control[POS_BYTE_SWAP];
   wire halfword_swap_enable = window1_control[POS_HALFWORD_SWAP];
   wire pixel_format_t pixel_format_select = pixel_format_t'(window1_control[POS_FORMAT_HI:POS_FORMAT_LO]);

   // Burst length decode; the unused code falls back to the longest burst
   wire [4:0] burst_words = (dma_burst_size_select == BURST_CODE_8) ? BURST_WORDS_8 :
                            (dma_burst_size_select == BURST_CODE_4) ? BURST_WORDS_4 :
                            BURST_WORDS_16;

   // Pixel format decode
   logic [5:0] bpp;
   logic has_alpha;
   logic palette;
   logic fmt_reserved;
   always_comb begin
      bpp = 6'h00;
      has_alpha = 1'b0;
      palette = 1'b0;
      fmt_reserved = 1'b0;
      unique case (pixel_format_select)
         FMT_1BPP: bpp = 6'h01;
         FMT_2BPP: bpp = 6'h02;
         FMT_4BPP: bpp = 6'h04;
         FMT_8BPP_PAL: begin
            bpp = 6'h08;
            palette = 1'b1;
         end
         FMT_A1R2G3B2: begin
            bpp = 6'h08;
            has_alpha = 1'b1;
         end
         FMT_R5G6B5: bpp = 6'h10;
         FMT_A1R5G5B5: begin
            bpp = 6'h10;
            has_alpha = 1'b1;
         end
         FMT_I1R5G5B5: bpp = 6'h10;
         FMT_R6G6B6: bpp = 6'h12;
         FMT_A1R6G6B5: begin
            bpp = 6'h12;
            has_alpha = 1'b1;
         end
         FMT_A1R6G6B6: begin
            bpp = 6'h13;
            has_alpha = 1'b1;
         end
         FMT_R8G8B8: bpp = 6'h18;
         FMT_A1R8G8B7: begin
            bpp = 6'h18;
            has_alpha = 1'b1;
         end
         FMT_A1R8G8B8: begin
            bpp = blend_category_select ? 6'h19 : 6'h1c;
            has_alpha = 1'b1;
         end
         FMT_RSVD_E, FMT_RSVD_F: fmt_reserved = 1'b1;
      endcase
   end

   // Alpha source selection
   wire alpha_source_t alpha_source = blend_category_select ?
        (alpha_sel ? ALPHA_PIXEL_DATA : ALPHA_PIXEL_FLAG) :
        (alpha_sel ? ALPHA_PLANE_SECOND : ALPHA_PLANE_FIRST);
   wire alpha_illegal = (alpha_source == ALPHA_PIXEL_DATA) && (pixel_format_select != FMT_R8G8B8);

   // Fetched data reordering: half-words, then bytes, then bit reversal
   wire [31:0] stage_half = halfword_swap_enable ? {fetch_data_i[15:0], fetch_data_i[31:16]} :
                            fetch_data_i;
   wire [31:0] stage_byte = byte_swap_enable ?
                            {stage_half[23:16], stage_half[31:24], stage_half[7:0], stage_half[15:8]} :
                            stage_half;
   logic [31:0] stage_bit;
   always_comb begin
      for (int i = 0; i < 32; i++) begin
         stage_bit[i] = bit_reverse_enable ? stage_byte[31-i] : stage_byte[i];
      end
   end

   // Status word
   wire [31:0] status_word = (32'(bpp) << POS_STAT_BPP_LO) | (32'(burst_words) << POS_STAT_BURST_LO) |
                             (32'(fmt_reserved) << POS_STAT_FMT_RSVD) |
                             (32'(alpha_illegal) << POS_STAT_ALPHA_ILLEGAL) |
                             (32'(has_alpha) << POS_STAT_HAS_ALPHA) | (32'(palette) << POS_STAT_PALETTE);

   // Read mux; unmapped addresses read zero
   wire [31:0] next_read_data = hit_control ? window1_control :
                                hit_top_left ? window0_top_left_position :
                                hit_bottom_right ? window0_bottom_right_position :
                                hit_status ? status_word : 32'h0000_0000;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         window1_control <= RESET_WINDOW1_CONTROL;
         window0_top_left_position <= RESET_POSITION;
         window0_bottom_right_position <= RESET_POSITION;
      end else if (write_strobe) begin
         if (hit_control) begin
            window1_control <= merge_bytes(window1_control, bus_wdata, wb_sel_i, MASK_WINDOW1_CONTROL);
         end
         if (hit_top_left) begin
            window0_top_left_position <= merge_bytes(window0_top_left_position, bus_wdata, wb_sel_i,
                                                     MASK_POSITION);
         end
         if (hit_bottom_right) begin
            window0_bottom_right_position <= merge_bytes(window0_bottom_right_position, bus_wdata, wb_sel_i,
                                                         MASK_POSITION);
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack <= 1'b0;
         read_data <= 32'h0000_0000;
      end else begin
         ack <= request;
         read_data <= request ? next_read_data : 32'h0000_0000;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         swapped_data <= 32'h0000_0000;
         video_data <= '0;
         video_ctl <= '0;
      end else begin
         swapped_data <= stage_bit;
         video_data <= video_data_i;
         video_ctl <= video_ctl_i;
      end
   end

   assign wb_ack_o = ack;
   assign wb_dat_o = DATA_W'(read_data);
   assign fetch_data_o = swapped_data;
   // Enable gates the staged video directly so a clear takes effect with no extra delay
   assign video_data_o = window_output_enable ? video_data : '0;
   assign video_ctl_o = window_output_enable ? video_ctl : '0;
   assign window_output_enable_o = window_output_enable;
   assign dma_burst_words_o = burst_words;
   assign blend_category_select_o = blend_category_select;
   assign bits_per_pixel_o = bpp;
   assign palette_indexed_o = palette;
   assign pixel_has_alpha_o = has_alpha;
   assign format_reserved_o = fmt_reserved;
   assign alpha_source_o = alpha_source;
   assign pixel_alpha_o = fetch_data_o[POS_PIXEL_ALPHA_HI:POS_PIXEL_ALPHA_LO];
   assign alpha_select_illegal_o = alpha_illegal;
   assign top_left_x_o = window0_top_left_position[POS_COORD_X_HI:POS_COORD_X_LO];
   assign top_left_y_o = window0_top_left_position[POS_COORD_Y_HI:POS_COORD_Y_LO];
   assign bottom_right_x_o = window0_bottom_right_position[POS_COORD_X_HI:POS_COORD_X_LO];
   assign bottom_right_y_o = window0_bottom_right_position[POS_COORD_Y_HI:POS_COORD_Y_LO];

   // Bit-order mirror of a word, used by the reversal check
   function automatic logic [31:0] mirror32(input logic [31:0] v);
      logic [31:0] m;
      for (int i = 0; i < 32; i++) begin
         m[i] = v[31-i];
      end
      return m;
   endfunction

   // Checks
   property p_reset_control;
      @(posedge clk_i) rst_i |=> (window1_control == 32'h0000_0000) && !window_output_enable_o;
   endproperty
   a_reset_control: assert property (p_reset_control) else $error("control not zero after reset");

   property p_video_gate;
      @(posedge clk_i) disable iff (rst_i) !window_output_enable_o |-> (video_data_o == '0) && (video_ctl_o == '0);
   endproperty
   a_video_gate: assert property (p_video_gate) else $error("video passes while window disabled");

   property p_video_pass;
      @(posedge clk_i) disable iff (rst_i)
         window_output_enable_o && $stable(window_output_enable_o) |-> video_ctl_o == $past(video_ctl_i);
   endproperty
   a_video_pass: assert property (p_video_pass) else $error("video control not passed when enabled");

   property p_bit_reverse;
      @(posedge clk_i) disable iff (rst_i)
         bit_reverse_enable && !byte_swap_enable && !halfword_swap_enable ##1 1'b1 |->
         fetch_data_o == mirror32($past(fetch_data_i));
   endproperty
   a_bit_reverse: assert property (p_bit_reverse) else $error("bit reversal wrong");

   property p_byte_swap;
      @(posedge clk_i) disable iff (rst_i)
         ($past(window1_control[18:16]) == 3'b010) |->
         fetch_data_o == {$past(fetch_data_i[23:16]), $past(fetch_data_i[31:24]),
                          $past(fetch_data_i[7:0]), $past(fetch_data_i[15:8])};
   endproperty
   a_byte_swap: assert property (p_byte_swap) else $error("byte swap wrong");

   property p_half_swap;
      @(posedge clk_i) disable iff (rst_i)
         ($past(window1_control[18:16]) == 3'b001) |->
         fetch_data_o == {$past(fetch_data_i[15:0]), $past(fetch_data_i[31:16])};
   endproperty
   a_half_swap: assert property (p_half_swap) else $error("half-word swap wrong");

   property p_burst;
      @(posedge clk_i) disable iff (rst_i)
         dma_burst_words_o == ((window1_control[10:9] == 2'h1) ? 5'h08 :
                               (window1_control[10:9] == 2'h2) ? 5'h04 : 5'h10);
   endproperty
   a_burst: assert property (p_burst) else $error("burst length decode wrong");

   property p_alpha_plane;
      @(posedge clk_i) disable iff (rst_i)
         !window1_control[6] |-> alpha_source_o == (window1_control[1] ? ALPHA_PLANE_SECOND : ALPHA_PLANE_FIRST);
   endproperty
   a_alpha_plane: assert property (p_alpha_plane) else $error("plane alpha set selection wrong");

   property p_alpha_illegal;
      @(posedge clk_i) disable iff (rst_i)
         (window1_control[6:1] == 6'b110111) |-> !alpha_select_illegal_o;
   endproperty
   a_alpha_illegal: assert property (p_alpha_illegal) else $error("24 bpp pixel alpha flagged illegal");

   property p_position_write;
      @(posedge clk_i) disable iff (rst_i)
         write_strobe && hit_top_left && (wb_sel_i == 4'hf) |=>
         {top_left_x_o, top_left_y_o} == $past(wb_dat_i[21:0]) ##1 !wb_ack_o;
   endproperty
   a_position_write: assert property (p_position_write) else $error("top-left write not stored");

   property p_reserved_read;
      @(posedge clk_i) disable iff (rst_i)
         wb_ack_o && $past(hit_control && !wb_we_i) |-> (wb_dat_o & ~MASK_WINDOW1_CONTROL) == 32'h0;
   endproperty
   a_reserved_read: assert property (p_reserved_read) else $error("reserved control bits read nonzero");
endmodule

/* rtl/overlay_window_pkg.sv */
package overlay_window_pkg;
   // Byte addresses of the registers on the bus
   localparam logic [31:0] ADDR_WINDOW1_CONTROL = 32'h4c80_0018;
   localparam logic [31:0] ADDR_WINDOW0_TOP_LEFT = 32'h4c80_0028;
   localparam logic [31:0] ADDR_WINDOW0_BOTTOM_RIGHT = 32'h4c80_002c;
   localparam logic [31:0] ADDR_WINDOW1_STATUS = 32'h4c80_00f0;

   // Reset values
   localparam logic [31:0] RESET_WINDOW1_CONTROL = 32'h0000_0000;
   localparam logic [31:0] RESET_POSITION = 32'h0000_0000;

   // Writable bits; all others are reserved and read as zero
   localparam logic [31:0] MASK_WINDOW1_CONTROL = 32'h0007_067f;
   localparam logic [31:0] MASK_POSITION = 32'h003f_ffff;

   // Control register fields
   localparam int POS_ENABLE = 0;
   localparam int POS_ALPHA_SEL = 1;
   localparam int POS_FORMAT_LO = 2;
   localparam int POS_FORMAT_HI = 5;
   localparam int POS_BLEND = 6;
   localparam int POS_BURST_LO = 9;
   localparam int POS_BURST_HI = 10;
   localparam int POS_HALFWORD_SWAP = 16;
   localparam int POS_BYTE_SWAP = 17;
   localparam int POS_BIT_REVERSE = 18;

   // Position register fields
   localparam int POS_COORD_Y_LO = 0;
   localparam int POS_COORD_Y_HI = 10;
   localparam int POS_COORD_X_LO = 11;
   localparam int POS_COORD_X_HI = 21;

   // Pixel alpha bits in a fetched 24-bit pixel word
   localparam int POS_PIXEL_ALPHA_LO = 24;
   localparam int POS_PIXEL_ALPHA_HI = 27;

   // Burst length codes and their word counts
   localparam logic [1:0] BURST_CODE_16 = 2'h0;
   localparam logic [1:0] BURST_CODE_8 = 2'h1;
   localparam logic [1:0] BURST_CODE_4 = 2'h2;
   localparam logic [4:0] BURST_WORDS_16 = 5'h10;
   localparam logic [4:0] BURST_WORDS_8 = 5'h08;
   localparam logic [4:0] BURST_WORDS_4 = 5'h04;

   // Pixel format codes
   typedef enum logic [3:0] {
      FMT_1BPP = 4'h0, FMT_2BPP = 4'h1, FMT_4BPP = 4'h2, FMT_8BPP_PAL = 4'h3,
      FMT_A1R2G3B2 = 4'h4, FMT_R5G6B5 = 4'h5, FMT_A1R5G5B5 = 4'h6, FMT_I1R5G5B5 = 4'h7,
      FMT_R6G6B6 = 4'h8, FMT_A1R6G6B5 = 4'h9, FMT_A1R6G6B6 = 4'ha, FMT_R8G8B8 = 4'hb,
      FMT_A1R8G8B7 = 4'hc, FMT_A1R8G8B8 = 4'hd, FMT_RSVD_E = 4'he, FMT_RSVD_F = 4'hf
   } pixel_format_t;

   // Source of the blending alpha
   typedef enum logic [1:0] {
      ALPHA_PLANE_FIRST = 2'h0, ALPHA_PLANE_SECOND = 2'h1,
      ALPHA_PIXEL_FLAG = 2'h2, ALPHA_PIXEL_DATA = 2'h3
   } alpha_source_t;

   // Status register layout
   localparam int POS_STAT_BPP_LO = 0;
   localparam int POS_STAT_BPP_HI = 5;
   localparam int POS_STAT_BURST_LO = 8;
   localparam int POS_STAT_BURST_HI = 12;
   localparam int POS_STAT_FMT_RSVD = 16;
   localparam int POS_STAT_ALPHA_ILLEGAL = 17;
   localparam int POS_STAT_HAS_ALPHA = 18;
   localparam int POS_STAT_PALETTE = 19;
endpackage

/* testbench/tb_top.sv */
`timescale 1ns/1ns
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_fail++; $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module tb_top;
   import overlay_window_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0;
   logic [31:0] wb_adr_i = 32'h0;
   logic [3:0] wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0;
   logic [31:0] fetch_data_i = 32'h0;
   logic [31:0] video_data_i = 32'h0;
   logic [3:0] video_ctl_i = 4'h0;
   logic [31:0] wb_dat_o, fetch_data_o, video_data_o;
   logic wb_ack_o, window_output_enable_o, blend_category_select_o, palette_indexed_o;
   logic pixel_has_alpha_o, format_reserved_o, alpha_select_illegal_o;
   logic [3:0] video_ctl_o, pixel_alpha_o;
   logic [4:0] dma_burst_words_o;
   logic [5:0] bits_per_pixel_o;
   alpha_source_t alpha_source_o;
   logic [10:0] top_left_x_o, top_left_y_o, bottom_right_x_o, bottom_right_y_o;
   int n_fail = 0;
   int checks = 0;
   int cycles = 0;
   localparam logic [31:0] ADDR_UNMAPPED = 32'h4c80_0020;

   overlay_window_config_regs u_dut (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .fetch_data_i(fetch_data_i), .fetch_data_o(fetch_data_o), .video_data_i(video_data_i),
      .video_ctl_i(video_ctl_i), .video_data_o(video_data_o), .video_ctl_o(video_ctl_o),
      .window_output_enable_o(window_output_enable_o), .dma_burst_words_o(dma_burst_words_o),
      .blend_category_select_o(blend_category_select_o), .bits_per_pixel_o(bits_per_pixel_o),
      .palette_indexed_o(palette_indexed_o), .pixel_has_alpha_o(pixel_has_alpha_o),
      .format_reserved_o(format_reserved_o), .alpha_source_o(alpha_source_o), .pixel_alpha_o(pixel_alpha_o),
      .alpha_select_illegal_o(alpha_select_illegal_o), .top_left_x_o(top_left_x_o), .top_left_y_o(top_left_y_o),
      .bottom_right_x_o(bottom_right_x_o), .bottom_right_y_o(bottom_right_y_o)
   );

   always #50 clk_i = ~clk_i;

   // Cuts a hung run short
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         n_fail++;
         close_out();
      end
   end

   task automatic close_out();
      if (n_fail == 0 && checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // One classic Wishbone cycle, held until ack is sampled or 20 clocks pass
   task automatic wb(input logic [31:0] a, input logic we, input logic [3:0] s, input logic [31:0] d,
                     output logic [31:0] q);
      logic got;
      got = 1'b0;
      q = 32'h0;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_sel_i <= s;
      wb_dat_i <= d;
      for (int i = 0; i < 20 && !got; i++) begin
         @(posedge clk_i);
         if (wb_ack_o === 1'b1) begin
            got = 1'b1;
            q = wb_dat_o;
         end
      end
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
      `CHK("wb_ack_o", 1'b1, got)
   endtask

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] q;
      wb(a, 1'b1, 4'hf, d, q);
      @(negedge clk_i);
   endtask

   task automatic rd_chk(input string nm, input logic [31:0] a, input logic [31:0] e);
      logic [31:0] q;
      wb(a, 1'b0, 4'hf, 32'h0, q);
      `CHK(nm, e, q)
   endtask

   function automatic logic [31:0] ctl(input logic [3:0] fmt, input logic blend, input logic asel,
                                       input logic [1:0] burst, input logic [2:0] swp, input logic en);
      logic [31:0] w;
      w = 32'h0;
      w[POS_ENABLE] = en;
      w[POS_ALPHA_SEL] = asel;
      w[POS_FORMAT_HI:POS_FORMAT_LO] = fmt;
      w[POS_BLEND] = blend;
      w[POS_BURST_HI:POS_BURST_LO] = burst;
      w[POS_BIT_REVERSE:POS_HALFWORD_SWAP] = swp;
      return w;
   endfunction

   // Half-word swap, then byte swap within each half-word, then full bit reversal
   function automatic logic [31:0] reorder(input logic [31:0] v, input logic [2:0] swp);
      logic [31:0] w;
      w = swp[0] ? {v[15:0], v[31:16]} : v;
      w = swp[1] ? {w[23:16], w[31:24], w[7:0], w[15:8]} : w;
      for (int i = 0; i < 32; i++) begin
         v[i] = w[31 - i];
      end
      return swp[2] ? v : w;
   endfunction

   task automatic t_reset();
      rd_chk("window1_control", ADDR_WINDOW1_CONTROL, 32'h0);
      rd_chk("window0_top_left_position", ADDR_WINDOW0_TOP_LEFT, 32'h0);
      rd_chk("window0_bottom_right_position", ADDR_WINDOW0_BOTTOM_RIGHT, 32'h0);
      @(negedge clk_i);
      `CHK("window_output_enable_o", 1'b0, window_output_enable_o)
      `CHK("dma_burst_words_o", 5'h10, dma_burst_words_o)
      `CHK("blend_category_select_o", 1'b0, blend_category_select_o)
   endtask

   task automatic t_reserved();
      wr(ADDR_WINDOW1_CONTROL, 32'hffff_ffff);
      rd_chk("window1_control", ADDR_WINDOW1_CONTROL, 32'h0007_067f);
      wr(ADDR_UNMAPPED, 32'hffff_ffff);
      rd_chk("unmapped", ADDR_UNMAPPED, 32'h0);
      wr(ADDR_WINDOW1_CONTROL, 32'h0);
   endtask

   task automatic t_video();
      @(posedge clk_i);
      video_data_i <= 32'hdead_beef;
      video_ctl_i <= 4'h9;
      repeat (2) @(posedge clk_i);
      @(negedge clk_i);
      `CHK("video_data_o", 32'h0, video_data_o)
      `CHK("video_ctl_o", 4'h0, video_ctl_o)
      wr(ADDR_WINDOW1_CONTROL, ctl(4'h0, 1'b0, 1'b0, 2'h0, 3'h0, 1'b1));
      `CHK("window_output_enable_o", 1'b1, window_output_enable_o)
      `CHK("video_data_o", 32'hdead_beef, video_data_o)
      `CHK("video_ctl_o", 4'h9, video_ctl_o)
      @(posedge clk_i);
      video_data_i <= 32'h1234_5678;
      @(negedge clk_i);
      `CHK("video_data_o", 32'hdead_beef, video_data_o)
      @(negedge clk_i);
      `CHK("video_data_o", 32'h1234_5678, video_data_o)
      wr(ADDR_WINDOW1_CONTROL, 32'h0);
      `CHK("video_data_o", 32'h0, video_data_o)
      `CHK("video_ctl_o", 4'h0, video_ctl_o)
   endtask

   task automatic t_swap();
      logic [31:0] e;
      for (int s = 0; s < 8; s++) begin
         wr(ADDR_WINDOW1_CONTROL, ctl(4'h0, 1'b0, 1'b0, 2'h0, 3'(s), 1'b0));
         @(posedge clk_i);
         fetch_data_i <= 32'h1a34_80f1 ^ 32'(s);
         @(posedge clk_i);
         @(negedge clk_i);
         e = reorder(32'h1a34_80f1 ^ 32'(s), 3'(s));
         `CHK("fetch_data_o", e, fetch_data_o)
         `CHK("pixel_alpha_o", e[27:24], pixel_alpha_o)
      end
   endtask

   task automatic t_burst();
      logic [4:0] tab [4] = '{5'h10, 5'h08, 5'h04, 5'h10};
      for (int c = 0; c < 4; c++) begin
         wr(ADDR_WINDOW1_CONTROL, ctl(4'h0, 1'b0, 1'b0, 2'(c), 3'h0, 1'b0));
         `CHK("dma_burst_words_o", tab[c], dma_burst_words_o)
         rd_chk("status", ADDR_WINDOW1_STATUS, (32'(tab[c]) << POS_STAT_BURST_LO) | 32'h1);
      end
   endtask

   task automatic t_format();
      logic [5:0] bpp [16] = '{1, 2, 4, 8, 8, 16, 16, 16, 18, 18, 19, 24, 24, 25, 0, 0};
      logic [15:0] alpha_codes = 16'h3650;
      logic [5:0] e;
      for (int b = 0; b < 2; b++) begin
         for (int f = 0; f < 16; f++) begin
            wr(ADDR_WINDOW1_CONTROL, ctl(4'(f), 1'(b), 1'b0, 2'h0, 3'h0, 1'b0));
            e = (f == 13 && b == 0) ? 6'd28 : bpp[f];
            `CHK("bits_per_pixel_o", e, bits_per_pixel_o)
            `CHK("palette_indexed_o", 1'(f == 3), palette_indexed_o)
            `CHK("pixel_has_alpha_o", alpha_codes[f], pixel_has_alpha_o)
            `CHK("format_reserved_o", 1'(f >= 14), format_reserved_o)
         end
      end
   endtask

   task automatic t_alpha();
      logic [1:0] bl_as [5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h3};
      logic [3:0] fmt [5] = '{4'hb, 4'hb, 4'hb, 4'hb, 4'h5};
      for (int k = 0; k < 5; k++) begin
         wr(ADDR_WINDOW1_CONTROL, ctl(fmt[k], bl_as[k][1], bl_as[k][0], 2'h0, 3'h0, 1'b0));
         `CHK("blend_category_select_o", bl_as[k][1], blend_category_select_o)
         `CHK("alpha_source_o", bl_as[k], alpha_source_o)
         `CHK("alpha_select_illegal_o", 1'(k == 4), alpha_select_illegal_o)
      end
   endtask

   task automatic t_pos();
      logic [31:0] q;
      wr(ADDR_WINDOW1_CONTROL, ctl(4'hb, 1'b0, 1'b0, 2'h0, 3'h0, 1'b0));
      wr(ADDR_WINDOW0_TOP_LEFT, 32'hffff_ffff);
      rd_chk("window0_top_left_position", ADDR_WINDOW0_TOP_LEFT, 32'h003f_ffff);
      wb(ADDR_WINDOW0_TOP_LEFT, 1'b1, 4'h1, 32'h0, q);
      rd_chk("window0_top_left_position", ADDR_WINDOW0_TOP_LEFT, 32'h003f_ff00);
      wr(ADDR_WINDOW0_BOTTOM_RIGHT, 32'h0009_1c56);
      rd_chk("window0_bottom_right_position", ADDR_WINDOW0_BOTTOM_RIGHT, 32'h0009_1c56);
      @(negedge clk_i);
      `CHK("top_left_x_o", 11'h7ff, top_left_x_o)
      `CHK("top_left_y_o", 11'h700, top_left_y_o)
      `CHK("bottom_right_x_o", 11'h123, bottom_right_x_o)
      `CHK("bottom_right_y_o", 11'h456, bottom_right_y_o)
      wr(ADDR_WINDOW1_CONTROL, ctl(4'h3, 1'b0, 1'b0, 2'h0, 3'h0, 1'b0));
      wr(ADDR_WINDOW0_BOTTOM_RIGHT, 32'h0000_2000);
      `CHK("bottom_right_x_o", 11'h004, bottom_right_x_o)
   endtask

   initial begin
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset();
      t_reserved();
      t_video();
      t_swap();
      t_burst();
      t_format();
      t_alpha();
      t_pos();
      close_out();
   end
endmodule
